// ### ccz_map.svh
// Register map, field positions and reset values of the comparator control register
// Operation
// - Polarity bit set inverts output status and pin
// - Status reads 1 when positive input wins
// - Speed/power select resets to one always
// - Hysteresis enable bit, read/write, resets zero
// - Disabled comparator disconnects all its inputs
// - Sync mode latches on timer clock fall
// - Pin driven only if drive, enable, direction clear
// - Speed/power one normal, zero low power
`ifndef CCZ_MAP_SVH
`define CCZ_MAP_SVH

// Byte address of the control register on the bus
`define CCZ_OFF_CTRL0 8'h00

// Field positions
`define CCZ_BIT_ON 7
`define CCZ_BIT_OUT 6
`define CCZ_BIT_OE 5
`define CCZ_BIT_POL 4
`define CCZ_BIT_RSV 3
`define CCZ_BIT_SP 2
`define CCZ_BIT_HYS 1
`define CCZ_BIT_SYNC 0

// Reset value and the mask of bits software may change
`define CCZ_RST_CTRL0 8'h04
`define CCZ_WR_MASK 8'hB7

`endif

// ### ccz_pkg.sv
// Types shared by the comparator control register design
package ccz_pkg;
    // Bus answer states, one-hot
    typedef enum logic [1:0] {
        CCZ_ST_IDLE = 2'b01,
        CCZ_ST_ACK = 2'b10
    } ccz_bus_e;

    typedef logic [7:0] ccz_byte_t;
endpackage

// ### ccz_reg.sv
// Comparator control register zero with Wishbone slave and output path
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ccz_map.svh"
module ccz_reg
    import ccz_pkg::*;
#(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog side
    input wire logic cmp_raw_i,
    input wire logic timer_clk_i,
    input wire logic pin_direction_bit_i,
    output logic cmp_enable_o,
    output logic cmp_input_connect_o,
    output logic cmp_speed_power_select_o,
    output logic cmp_hysteresis_enable_o,
    output logic cmp_result_o,
    output logic cmp_pin_o,
    output logic cmp_pin_oe_o
);
    // Register and bus state
    ccz_byte_t ctrl_r;
    ccz_byte_t ctrl_nxt;
    ccz_bus_e st_r;
    ccz_bus_e st_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic hit;
    logic wr_en;
    logic req;

    // Comparator path state
    logic raw_q;
    logic tmr_fall;
    logic cmp_val;
    logic pol_val;
    logic out_val;
    logic sync_lat_r;
    logic sync_lat_nxt;
    logic result_r;
    logic result_nxt;
    logic pin_r;
    logic pin_nxt;
    logic pin_oe_r;
    logic pin_oe_nxt;
    logic en_r;
    logic en_nxt;
    logic sp_r;
    logic sp_nxt;
    logic hys_r;
    logic hys_nxt;

    // Address decode shared by read and write
    function automatic logic addr_hit(input logic [ADR_W-1:0] a);
        addr_hit = (a == ADR_W'(`CCZ_OFF_CTRL0));
    endfunction

    // Pin-side inputs cross in through two flops each
    ccz_sync_fall u_raw_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(cmp_raw_i),
        .q_o(raw_q),
        .fall_o()
    );

    ccz_sync_fall u_tmr_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(timer_clk_i),
        .q_o(),
        .fall_o(tmr_fall)
    );

    // Bus request qualifiers
    assign req = wb_cyc_i & wb_stb_i;
    assign hit = addr_hit(wb_adr_i);
    // Write commits at the edge where the master sees ack
    assign wr_en = req & ack_r & wb_we_i & wb_sel_i[0] & hit;

    // Bus state: answer one cycle after request, drop ack the cycle after
    always_comb begin
        st_nxt = st_r;
        ack_nxt = 1'b0;
        rdat_nxt = rdat_r;
        case (st_r)
            CCZ_ST_IDLE: begin
                if (req) begin
                    st_nxt = CCZ_ST_ACK;
                    ack_nxt = 1'b1;
                    // Unmapped reads return zero; status bit is live state
                    rdat_nxt = 32'h0000_0000;
                    if (hit && !wb_we_i) begin
                        rdat_nxt[7:0] = ctrl_r;
                        rdat_nxt[`CCZ_BIT_OUT] = result_r;
                    end
                end
            end
            CCZ_ST_ACK: begin
                st_nxt = CCZ_ST_IDLE;
            end
            default: begin
                st_nxt = CCZ_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= CCZ_ST_IDLE;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // Control register; status and reserved bits never stored
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_en) begin
            ctrl_nxt = wb_dat_i[7:0] & `CCZ_WR_MASK;
        end
    end

    // Every reset reloads the defaults, speed bit high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `CCZ_RST_CTRL0;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Result path: gate, invert, optionally latch on timer fall
    always_comb begin
        cmp_val = raw_q & ctrl_r[`CCZ_BIT_ON];
        pol_val = cmp_val ^ ctrl_r[`CCZ_BIT_POL];
        sync_lat_nxt = sync_lat_r;
        if (tmr_fall) begin
            sync_lat_nxt = pol_val;
        end
        out_val = ctrl_r[`CCZ_BIT_SYNC] ? sync_lat_r : pol_val;
        result_nxt = out_val;
        pin_oe_nxt = ctrl_r[`CCZ_BIT_OE] & ctrl_r[`CCZ_BIT_ON]
                     & ~pin_direction_bit_i;
        // Drive low when not enabled so the pin never sees stale data
        pin_nxt = pin_oe_nxt & out_val;
        en_nxt = ctrl_r[`CCZ_BIT_ON];
        sp_nxt = ctrl_r[`CCZ_BIT_SP];
        hys_nxt = ctrl_r[`CCZ_BIT_HYS];
    end

    // Output flops; one cycle of delay buys glitch-free pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_lat_r <= 1'b0;
            result_r <= 1'b0;
            pin_r <= 1'b0;
            pin_oe_r <= 1'b0;
            en_r <= 1'b0;
            sp_r <= 1'b1;
            hys_r <= 1'b0;
        end else begin
            sync_lat_r <= sync_lat_nxt;
            result_r <= result_nxt;
            pin_r <= pin_nxt;
            pin_oe_r <= pin_oe_nxt;
            en_r <= en_nxt;
            sp_r <= sp_nxt;
            hys_r <= hys_nxt;
        end
    end

    assign cmp_result_o = result_r;
    assign cmp_pin_o = pin_r;
    assign cmp_pin_oe_o = pin_oe_r;
    assign cmp_enable_o = en_r;
    // Inputs connect only while enabled
    assign cmp_input_connect_o = en_r;
    assign cmp_speed_power_select_o = sp_r;
    assign cmp_hysteresis_enable_o = hys_r;

    // Checks on the register and result path
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_pol_invert: assert property (
        !ctrl_r[`CCZ_BIT_SYNC] |=>
            result_r == $past((raw_q & ctrl_r[`CCZ_BIT_ON]) ^ ctrl_r[`CCZ_BIT_POL])
    ) else $error("Result not inverted per polarity bit");

    a_status_read: assert property (
        (st_r == CCZ_ST_IDLE && req && hit && !wb_we_i) |=>
            wb_ack_o && wb_dat_o[`CCZ_BIT_OUT] == $past(result_r)
    ) else $error("Status bit read does not show result");

    a_reset_value: assert property (
        @(posedge clk_i) disable iff (1'b0) rst_i |=> ctrl_r == `CCZ_RST_CTRL0 && sp_r
    ) else $error("Reset did not load defaults");

    a_hys_follow: assert property (
        wr_en |=> ##1 cmp_hysteresis_enable_o == $past(wb_dat_i[`CCZ_BIT_HYS], 2)
    ) else $error("Hysteresis enable did not follow write");

    a_rsv_zero: assert property (
        (ack_r && !wb_we_i) |-> wb_dat_o[`CCZ_BIT_RSV] == 1'b0
            && wb_dat_o[31:8] == 24'h00_0000
    ) else $error("Reserved bits read nonzero");

    a_inputs_off: assert property (
        !ctrl_r[`CCZ_BIT_ON] |=> !cmp_input_connect_o && !cmp_pin_oe_o
    ) else $error("Inputs still connected while disabled");

    a_sync_hold: assert property (
        (ctrl_r[`CCZ_BIT_SYNC] && !tmr_fall) |=> $stable(sync_lat_r)
    ) else $error("Sync latch moved without timer fall");

    a_sync_take: assert property (
        (ctrl_r[`CCZ_BIT_SYNC] && tmr_fall) |=> ##1 result_r == $past(pol_val, 2)
    ) else $error("Sync result not taken at timer fall");

    a_pin_drive: assert property (
        cmp_pin_oe_o |-> $past(ctrl_r[`CCZ_BIT_OE] && ctrl_r[`CCZ_BIT_ON]
            && !pin_direction_bit_i)
    ) else $error("Pin driven without all three conditions");

    a_speed_sel: assert property (
        ctrl_r[`CCZ_BIT_SP] == !$past(ctrl_r[`CCZ_BIT_SP]) |=>
            cmp_speed_power_select_o == $past(ctrl_r[`CCZ_BIT_SP])
    ) else $error("Speed select output did not follow bit");

    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o
    ) else $error("Ack held longer than one cycle");

    // Guards on the stored byte, refused writes and the pin data path
    // Stored copy never holds the status or unimplemented bit
    a_ctrl_unstored: assert property (
        ctrl_r[`CCZ_BIT_OUT] == 1'b0 && ctrl_r[`CCZ_BIT_RSV] == 1'b0
    ) else $error("Status or unimplemented bit stored");

    a_write_lands: assert property (
        wr_en |=> ctrl_r == ($past(wb_dat_i[7:0]) & `CCZ_WR_MASK)
    ) else $error("Written byte not stored");

    // Lane off or another address must leave the register alone
    a_write_refused: assert property (
        (req && ack_r && wb_we_i && !(wb_sel_i[0] && hit)) |=> $stable(ctrl_r)
    ) else $error("Refused write changed the register");

    a_enable_follow: assert property (
        ctrl_r[`CCZ_BIT_ON] |=> cmp_enable_o && cmp_input_connect_o
    ) else $error("Enable output did not follow bit");

    // Disabled comparator reads as raw zero, so only polarity shows
    a_off_polarity: assert property (
        (!ctrl_r[`CCZ_BIT_ON] && !ctrl_r[`CCZ_BIT_SYNC]) |=>
            cmp_result_o == $past(ctrl_r[`CCZ_BIT_POL])
    ) else $error("Disabled result is not the polarity bit");

    // Pin data stays low whenever the driver is off
    a_pin_quiet: assert property (
        !cmp_pin_oe_o |-> !cmp_pin_o
    ) else $error("Pin data set while not driving");

    a_status_pin: assert property (
        cmp_pin_oe_o |-> cmp_pin_o == cmp_result_o
    ) else $error("Pin shows other value than status");

    a_ack_answer: assert property (
        (st_r == CCZ_ST_IDLE && req) |=> wb_ack_o
    ) else $error("Request not answered in one cycle");

    c_write_read: cover property (
        wr_en ##[2:10] (ack_r && !wb_we_i)
    );

    c_sync_latch: cover property (
        ctrl_r[`CCZ_BIT_SYNC] && tmr_fall && pol_val
    );

    c_pin_drive: cover property (
        cmp_pin_oe_o && cmp_pin_o
    );

    c_low_power: cover property (
        !cmp_speed_power_select_o && cmp_enable_o
    );

    c_refused_write: cover property (
        req && ack_r && wb_we_i && !wb_sel_i[0]
    );
endmodule // ccz_reg

// ### ccz_reg_tb.sv
// Self-checking bench for the comparator control register
`timescale 1ns/1ps
module ccz_reg_tb
    import ccz_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic raw = 1'b0;
    logic tmr = 1'b1;
    logic dir = 1'b0;
    logic en_o, conn_o, sp_o, hys_o, res_o, pin_o, oe_o;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    ccz_byte_t rd;

    ccz_reg #(.ADR_W(8)) i_ccz_reg (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_raw_i(raw), .timer_clk_i(tmr),
        .pin_direction_bit_i(dir), .cmp_enable_o(en_o), .cmp_input_connect_o(conn_o),
        .cmp_speed_power_select_o(sp_o), .cmp_hysteresis_enable_o(hys_o),
        .cmp_result_o(res_o), .cmp_pin_o(pin_o), .cmp_pin_oe_o(oe_o));

    // Free-running 125 MHz clock
    always #4 clk_i = ~clk_i;

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input ccz_byte_t d,
            input logic [3:0] s, output ccz_byte_t q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat[7:0];
        check(32'(rdat[31:8]), 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input ccz_byte_t d, input logic [3:0] s);
        ccz_byte_t q;
        bus(1'b1, a, d, s, q);
        idle(6);
    endtask

    task automatic rdchk(input logic [7:0] a, input ccz_byte_t exp);
        ccz_byte_t q;
        bus(1'b0, a, 8'h00, 4'hF, q);
        check(q, exp);
    endtask

    initial begin
        idle(8);
        rst_i <= 1'b0;
        idle(1);
        // Reset state: only speed/power set
        rdchk(8'h00, 8'h04);
        check({en_o, sp_o, hys_o, res_o, oe_o}, 5'b01000);
        $display("test reset done");
        // All ones: sync latch has seen no timer fall, status holds zero; bit 3 clear
        wr(8'h00, 8'hFF, 4'h1);
        rdchk(8'h00, 8'hB7);
        check({en_o, conn_o, sp_o, hys_o}, 4'hF);
        // Unmapped address and cleared byte lane leave it alone
        wr(8'h04, 8'h00, 4'h1);
        wr(8'h00, 8'h00, 4'h0);
        rdchk(8'h04, 8'h00);
        rdchk(8'h00, 8'hB7);
        $display("test access done");
        // Polarity against raw decision, low power selected
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 2; r++) begin
                wr(8'h00, 8'(8'hA0 | (p << 4)), 4'h1);
                raw <= r[0];
                idle(6);
                check({res_o, pin_o, oe_o, sp_o}, {r[0] ^ p[0], r[0] ^ p[0], 2'b10});
                rdchk(8'h00, 8'(8'hA0 | (p << 4) | ((r ^ p) << 6)));
            end
        end
        $display("test polarity done");
        // Direction bit set keeps the pin undriven
        dir <= 1'b1;
        idle(4);
        check({pin_o, oe_o}, 2'b00);
        dir <= 1'b0;
        // Disabled: inputs cut, result is the polarity bit, pin off
        wr(8'h00, 8'h34, 4'h1);
        check({en_o, conn_o, res_o, oe_o, pin_o}, 5'b00100);
        $display("test disable done");
        // Sync mode: result moves only at a timer fall; first fall latches a low decision
        raw <= 1'b0;
        wr(8'h00, 8'h85, 4'h1);
        tmr <= 1'b0;
        idle(6);
        raw <= 1'b1;
        tmr <= 1'b1;
        idle(8);
        check(res_o, 1'b0);
        tmr <= 1'b0;
        idle(8);
        check(res_o, 1'b1);
        wr(8'h00, 8'h84, 4'h1);
        raw <= 1'b0;
        idle(6);
        check(res_o, 1'b0);
        $display("test sync done");
        final_report();
    end
endmodule // ccz_reg_tb

// ### ccz_sync_fall.sv
// Two-stage synchroniser with falling edge detector on the settled level
`timescale 1ns/1ps
module ccz_sync_fall (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o,
    output logic fall_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic s1_nxt;
    logic s2_nxt;
    logic s3_nxt;

    // Next values; stage one feeds only stage two to keep metastability contained
    always_comb begin
        s1_nxt = d_i;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // Edge seen only between settled stages
    assign q_o = s2_r;
    assign fall_o = s3_r & ~s2_r;
endmodule // ccz_sync_fall
